/* File: ppbm_defs.vh */
// Purpose: Constants for the parallel port and bus mode block.
// Assumes: APB register map with 32-bit aligned words.
// Notes: Offsets are byte addresses.
`ifndef PPBM_DEFS_VH
`define PPBM_DEFS_VH
`define PPBM_OFF_PORTA 12'h000
`define PPBM_OFF_PORTB 12'h004
`define PPBM_OFF_PORTC 12'h008
`define PPBM_OFF_MODE 12'h00c
`define PPBM_OFF_IFLAG 12'h010
`define PPBM_OFF_IEN 12'h014
`define PPBM_OFF_HOST_OUT 12'h018
`define PPBM_OFF_HOST_IN 12'h01c
`define PPBM_OFF_HOST_FLAG 12'h020
`define PPBM_OFF_BUSREQ 12'h024
`define PPBM_OFF_BUSRD 12'h028
`define PPBM_MODE_PB_LO 6
`define PPBM_MODE_PB_HI 7
`define PPBM_MODE_IRQSEL 5
`define PPBM_MODE_CM0 0
`define PPBM_MODE_CM1 1
`define PPBM_PORT_RST 8'hff
`define PPBM_MODE_RST 8'h00
`define PPBM_EXTSEL_LO 12'h080
`define PPBM_EXTSEL_HI 12'hfff
`define PPBM_HF_IDRF 0
`define PPBM_HF_ODRF 7
`define PPBM_HF_F1 1
`endif

/* File: ppbm_ext_mem.sv */
// Purpose: External memory on the multiplexed port bus.
// Assumes: Select low marks a bus cycle; phase 2 follows phase 1.
// Notes: Released data lines show the inverse of the last value.
module ppbm_ext_mem #(
    parameter int SEL_BIT = 4
) (
    input wire logic clk_i,
    input wire logic [7:0] bus_i,
    input wire logic [7:0] bus_oe_n_i,
    input wire logic [6:0] ctl_i,
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:4095];
    logic [7:0] hi_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    logic sel_q = 1'b1;
    wire ph2 = !sel_q && !ctl_i[SEL_BIT];
    wire [11:0] addr = {hi_q, ctl_i[3:0]};
    assign data_o = ph2 ? mem[addr] : ~last_q;
    always @(posedge clk_i)
    begin
        sel_q <= ctl_i[SEL_BIT];
        last_q <= data_o;
        if (sel_q && !ctl_i[SEL_BIT])
            hi_q <= bus_i;
        if (ph2 && bus_oe_n_i == 8'h00)
            mem[addr] <= bus_i;
    end
endmodule // ppbm_ext_mem

/* File: ppbm_top.v */
// Purpose: Ports A, B, C with bus modes and the host data registers.
// Assumes: APB slave on clk_sys_i; host strobes synchronous one-cycle pulses.
// Notes: Bus cycles are two clocks, phase 1 then phase 2.
//
// Operation
// [RQ1] Port A or C line with register bit one is an input read back.
// [RQ2] Reset sets every port register bit to one.
// [RQ3] Ordinary port read returns pin levels.
// [RQ4] Read-modify-write read returns port register contents.
// [RQ5] Output line drives high for one and low for zero.
// [RQ6] Both Port B mode bits zero: Port B all inputs, floated.
// [RQ7] Mode bit 6 one, bit 7 zero: Port B drives register.
// [RQ8] Rising edge line 0, falling line 1 set flags, enabled request.
// [RQ9] Edges resolved up to half the clock rate.
// [RQ10] Port A bit-independent; line 2 is counter line in counter modes.
// [RQ11] Bus modes: Port C 0..5 drive address, read/write, memory select.
// [RQ12] Abbreviated mode: Port B is bidirectional data bus.
// [RQ13] Multiplexed mode: Port B address 4..11 then data.
// [RQ14] Abbreviated mode decodes sixteen peripheral addresses.
// [RQ15] Multiplexed mode gives full 4K address range.
// [RQ16] Memory select low for accesses 0080 through 0fff.
// [RQ17] Outside logic latches Port B address on select leading edge.
// [RQ18] Bus mode data drivers on only in phase 2 of writes.
// [RQ19] Port C line 6 is I/O or host interrupt per mode bit 5.
// [RQ20] Host select high: read status flags, write is a command.
// [RQ21] Host select low: read output register, write input register.
`include "ppbm_defs.vh"
module ppbm_top #(
    parameter PW = 8
) (
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [7:0] porta_i,
    output reg [7:0] porta_o,
    output reg [7:0] porta_oe_n_o,
    input wire [7:0] portb_i,
    output reg [7:0] portb_o,
    output reg [7:0] portb_oe_n_o,
    input wire [6:0] portc_i,
    output reg [6:0] portc_o,
    output reg [6:0] portc_oe_n_o,
    output reg irq_o,
    input wire host_cs_i,
    input wire host_rd_i,
    input wire host_wr_i,
    input wire host_reg_select_i,
    input wire [7:0] host_data_i,
    output reg [7:0] host_data_o
);
    localparam BS_IDLE = 2'd0;
    localparam BS_PH1 = 2'd1;
    localparam BS_PH2 = 2'd2;
    localparam BS_DONE = 2'd3;
    reg [7:0] pa_q, pb_q, mode_control_reg_q, ien_q;
    reg [6:0] pc_q;
    reg [1:0] interrupt_flag_reg_q;
    reg [7:0] host_output_reg_q, host_input_reg_q, host_cmd_q;
    reg [7:0] host_flag_reg_q;
    reg [1:0] edge_prev_q;
    reg [1:0] bs_q;
    reg [11:0] baddr_q;
    reg [7:0] bwdata_q, brdata_q;
    reg bwrite_q, bbusy_q;
    wire apb_acc = psel & penable;
    wire apb_wr = apb_acc & pwrite;
    wire apb_rd = apb_acc & ~pwrite;
    // Address bit 11 marks the read half of a read-modify-write access.
    wire rmw = paddr[11];
    wire [11:0] off = {1'b0, paddr[10:0]};
    wire mode_lo = mode_control_reg_q[`PPBM_MODE_PB_LO];
    wire mode_hi = mode_control_reg_q[`PPBM_MODE_PB_HI];
    wire bus_mode = mode_hi;
    wire mux_mode = mode_hi & mode_lo;
    wire [1:0] cmode = {mode_control_reg_q[`PPBM_MODE_CM1], mode_control_reg_q[`PPBM_MODE_CM0]};
    wire host_wr = host_cs_i & host_wr_i;
    wire host_rd = host_cs_i & host_rd_i;
    // [RQ8] Edge detection.
    wire rise0 = porta_i[0] & ~edge_prev_q[0];
    wire fall1 = ~porta_i[1] & edge_prev_q[1];
    // [RQ16] Memory select window.
    wire ext_sel_hit = (pwdata[11:0] >= `PPBM_EXTSEL_LO) && (pwdata[11:0] <= `PPBM_EXTSEL_HI);
    reg [31:0] rd_d;
    always @*
    begin
        rd_d = 32'h0;
        case (off)
            // [RQ3] Pins normally, [RQ4] register on RMW read.
            `PPBM_OFF_PORTA: rd_d = {24'h0, rmw ? pa_q : porta_i};
            `PPBM_OFF_PORTB: rd_d = {24'h0, rmw ? pb_q : portb_i};
            `PPBM_OFF_PORTC: rd_d = {25'h0, rmw ? pc_q : portc_i};
            `PPBM_OFF_MODE: rd_d = {24'h0, mode_control_reg_q};
            `PPBM_OFF_IFLAG: rd_d = {30'h0, interrupt_flag_reg_q};
            `PPBM_OFF_IEN: rd_d = {24'h0, ien_q};
            `PPBM_OFF_HOST_OUT: rd_d = {24'h0, host_output_reg_q};
            `PPBM_OFF_HOST_IN: rd_d = {16'h0, host_cmd_q, host_input_reg_q};
            `PPBM_OFF_HOST_FLAG: rd_d = {24'h0, host_flag_reg_q};
            `PPBM_OFF_BUSREQ: rd_d = {31'h0, bbusy_q};
            `PPBM_OFF_BUSRD: rd_d = {24'h0, brdata_q};
            default: rd_d = 32'h0;
        endcase
    end
    wire known = (off <= `PPBM_OFF_BUSRD) && (off[1:0] == 2'b00);
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            // [RQ2] Port registers all ones.
            pa_q <= `PPBM_PORT_RST;
            pb_q <= `PPBM_PORT_RST;
            pc_q <= 7'h7f;
            mode_control_reg_q <= `PPBM_MODE_RST;
            ien_q <= 8'h00;
            interrupt_flag_reg_q <= 2'b00;
            host_output_reg_q <= 8'h00;
            host_input_reg_q <= 8'h00;
            host_cmd_q <= 8'h00;
            host_flag_reg_q <= 8'h00;
            edge_prev_q <= 2'b11;
            bs_q <= BS_IDLE;
            baddr_q <= 12'h000;
            bwdata_q <= 8'h00;
            brdata_q <= 8'h00;
            bwrite_q <= 1'b0;
            bbusy_q <= 1'b0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            // [RQ9] One-clock sampling resolves edges at half rate.
            edge_prev_q <= porta_i[1:0];
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~known;
            prdata <= (psel & ~penable & ~pwrite) ? rd_d : 32'h0;
            if (apb_wr & known)
            begin
                case (off)
                    `PPBM_OFF_PORTA: pa_q <= pwdata[7:0];
                    `PPBM_OFF_PORTB: pb_q <= pwdata[7:0];
                    `PPBM_OFF_PORTC: pc_q <= pwdata[6:0];
                    `PPBM_OFF_MODE: mode_control_reg_q <= pwdata[7:0];
                    `PPBM_OFF_IEN: ien_q <= pwdata[7:0];
                    `PPBM_OFF_HOST_OUT: host_output_reg_q <= pwdata[7:0];
                    default: ;
                endcase
            end
            // Flags: hardware set wins over software clear (write one to clear).
            // [RQ8] Edge flags.
            interrupt_flag_reg_q <= (interrupt_flag_reg_q &
                ~((apb_wr && off == `PPBM_OFF_IFLAG) ? pwdata[1:0] : 2'b00))
                | {fall1, rise0};
            // [RQ21] Select low: data in and data out.
            if (host_wr & ~host_reg_select_i)
                host_input_reg_q <= host_data_i;
            // [RQ20] Select high write is a command.
            if (host_wr & host_reg_select_i)
                host_cmd_q <= host_data_i;
            if (host_wr)
                host_flag_reg_q[`PPBM_HF_F1] <= host_reg_select_i;
            if (host_wr)
                host_flag_reg_q[`PPBM_HF_IDRF] <= 1'b1;
            else if (apb_rd && off == `PPBM_OFF_HOST_IN)
                host_flag_reg_q[`PPBM_HF_IDRF] <= 1'b0;
            if (apb_wr && off == `PPBM_OFF_HOST_OUT)
                host_flag_reg_q[`PPBM_HF_ODRF] <= 1'b1;
            else if (host_rd & ~host_reg_select_i)
                host_flag_reg_q[`PPBM_HF_ODRF] <= 1'b0;
            // Bus engine: the processor requests an access by writing the bus request register.
            case (bs_q)
                BS_IDLE:
                begin
                    if (apb_wr && off == `PPBM_OFF_BUSREQ && bus_mode && ext_sel_hit)
                    begin
                        baddr_q <= pwdata[11:0];
                        bwrite_q <= pwdata[12];
                        bwdata_q <= pwdata[23:16];
                        bbusy_q <= 1'b1;
                        bs_q <= BS_PH1;
                    end
                end
                BS_PH1: bs_q <= BS_PH2;
                // Phase 2 only reaches the pins after this edge, so read data is taken a clock later.
                BS_PH2: bs_q <= BS_DONE;
                BS_DONE:
                begin
                    if (~bwrite_q)
                        brdata_q <= portb_i;
                    bbusy_q <= 1'b0;
                    bs_q <= BS_IDLE;
                end
                default: bs_q <= BS_IDLE;
            endcase
        end
    end
    integer i;
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            porta_o <= 8'hff;
            porta_oe_n_o <= 8'hff;
            portb_o <= 8'hff;
            portb_oe_n_o <= 8'hff;
            portc_o <= 7'h7f;
            portc_oe_n_o <= 7'h7f;
            irq_o <= 1'b0;
            host_data_o <= 8'h00;
        end
        else
        begin
            // [RQ1] [RQ5] [RQ10] Register one means input; zero drives low.
            porta_o <= pa_q;
            porta_oe_n_o <= pa_q;
            if (cmode == 2'b01)
            begin
                porta_oe_n_o[2] <= 1'b0;
                porta_o[2] <= pa_q[2];
            end
            else if (cmode[1])
                porta_oe_n_o[2] <= 1'b1;
            // [RQ6] [RQ7] Port B I/O modes.
            if (!bus_mode)
            begin
                portb_o <= pb_q;
                portb_oe_n_o <= mode_lo ? 8'h00 : 8'hff;
            end
            // [RQ13] [RQ15] Address 4..11 in phase 1.
            else if (mux_mode && bs_q == BS_PH1)
            begin
                portb_o <= baddr_q[11:4];
                portb_oe_n_o <= 8'h00;
            end
            // [RQ12] [RQ18] Data drivers only in write phase 2.
            else
            begin
                portb_o <= bwdata_q;
                portb_oe_n_o <= (bs_q == BS_PH2 && bwrite_q) ? 8'h00 : 8'hff;
            end
            for (i = 0; i < 6; i = i + 1)
            begin
                portc_o[i] <= pc_q[i];
                portc_oe_n_o[i] <= pc_q[i];
            end
            if (bus_mode)
            begin
                // [RQ11] [RQ14] Low address, read/write and select driven.
                portc_o[3:0] <= baddr_q[3:0];
                portc_o[4] <= ~(bs_q == BS_PH1 || bs_q == BS_PH2);
                portc_o[5] <= ~bwrite_q;
                portc_oe_n_o[5:0] <= 6'h00;
            end
            // [RQ19] Line 6 is I/O or host interrupt.
            if (mode_control_reg_q[`PPBM_MODE_IRQSEL])
            begin
                portc_o[6] <= ~host_flag_reg_q[`PPBM_HF_ODRF];
                portc_oe_n_o[6] <= 1'b0;
            end
            else
            begin
                portc_o[6] <= pc_q[6];
                portc_oe_n_o[6] <= pc_q[6];
            end
            irq_o <= |(interrupt_flag_reg_q & ien_q[1:0]);
            // [RQ20] [RQ21] Host read data.
            host_data_o <= host_reg_select_i ? host_flag_reg_q : host_output_reg_q;
        end
    end
endmodule // ppbm_top

/* File: ppbm_top_props.sv */
// Purpose: Port and bus checks for the parallel port block.
// Assumes: Mode and Port A writes are seen on the APB ports.
// Notes: Port outputs lag the shadows by one clock, so checks wait for stability.
`include "ppbm_defs.vh"
module ppbm_props (
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [7:0] porta_o,
    input wire [7:0] porta_oe_n_o,
    input wire [7:0] portb_oe_n_o,
    input wire [6:0] portc_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mode_q;
    logic [7:0] pa_q;
    logic [2:0] idle_q;
    wire wr = psel && penable && pwrite && pready && !pslverr;
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            mode_q <= 8'h00;
            pa_q <= 8'hff;
            idle_q <= 3'h0;
        end
        else
        begin
            if (wr && paddr == `PPBM_OFF_MODE)
                mode_q <= pwdata[7:0];
            if (wr && paddr == `PPBM_OFF_PORTA)
                pa_q <= pwdata[7:0];
            idle_q <= (wr && paddr == `PPBM_OFF_BUSREQ) ? 3'h0 : idle_q + {2'h0, idle_q != 3'h7};
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_reset_inputs: assert property ($past(sys_rst_i) |-> porta_oe_n_o == 8'hff
        && portb_oe_n_o == 8'hff && portc_oe_n_o == 7'h7f) else $error("ports not inputs");
    a_ready_setup: assert property (s_setup |=> s_access ##0 pready) else $error("no ready");
    a_ready_only: assert property (pready |-> psel && penable) else $error("stray ready");
    a_err_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
        else $error("refused read data");
    a_porta_follow: assert property (mode_q[1:0] == 2'b00 && $stable(pa_q) && $stable(mode_q)
        |-> porta_oe_n_o == pa_q && (porta_o & ~pa_q) == 8'h00) else $error("port a drive");
    a_portb_float: assert property (mode_q[7:6] == 2'b00 && $stable(mode_q)
        |-> portb_oe_n_o == 8'hff) else $error("port b not floated");
    a_portb_drive: assert property (mode_q[7:6] == 2'b01 && $stable(mode_q)
        |-> portb_oe_n_o == 8'h00) else $error("port b not driven");
    a_portc_bus: assert property (mode_q[7] && $stable(mode_q)
        |-> portc_oe_n_o[5:0] == 6'h00) else $error("port c bus lines");
    a_bus_quiet: assert property (mode_q[7] && $stable(mode_q) && idle_q == 3'h7
        |-> portb_oe_n_o == 8'hff) else $error("bus data driven idle");
endmodule // ppbm_props
bind ppbm_top ppbm_props u_props (.clk_sys_i, .sys_rst_i, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .porta_o, .porta_oe_n_o, .portb_oe_n_o, .portc_oe_n_o);

/* File: ppbm_top_test.sv */
// Purpose: Self-checking bench for the parallel port block.
// Assumes: Port A pins follow pa_ext unless driven low; Port B pins show driven data or the external memory.
// Notes: Port reads wait a few clocks so pin sampling can settle.
`include "ppbm_defs.vh"
module ppbm_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 0, sys_rst_i = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic host_cs_i = 0, host_rd_i = 0, host_wr_i = 0, host_reg_select_i = 0;
    logic [7:0] host_data_i = 8'h00, pa_ext = 8'h5a, mem_d;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic pready, pslverr, irq_o;
    logic [7:0] porta_o, porta_oe_n_o, portb_o, portb_oe_n_o, host_data_o;
    logic [6:0] portc_o, portc_oe_n_o;
    int num_errors = 0, tests_run = 0;
    wire [7:0] porta_i = pa_ext & (porta_oe_n_o | porta_o);
    wire [7:0] portb_i = (~portb_oe_n_o & portb_o) | (portb_oe_n_o & mem_d);
    wire [6:0] portc_i = ~portc_oe_n_o | portc_o;
    ppbm_top u_dut (.clk_sys_i, .sys_rst_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .porta_i, .porta_o, .porta_oe_n_o, .portb_i, .portb_o, .portb_oe_n_o,
        .portc_i, .portc_o, .portc_oe_n_o, .irq_o, .host_cs_i, .host_rd_i, .host_wr_i,
        .host_reg_select_i, .host_data_i, .host_data_o);
    ppbm_ext_mem u_mem (.clk_i(clk_sys_i), .bus_i(portb_o), .bus_oe_n_i(portb_oe_n_o),
        .ctl_i(portc_o), .data_o(mem_d));
    initial
    begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do @(posedge clk_sys_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic host(input logic r, input logic rs, input logic [7:0] d);
        @(posedge clk_sys_i);
        host_cs_i <= 1'b1;
        host_rd_i <= r;
        host_wr_i <= !r;
        host_reg_select_i <= rs;
        host_data_i <= d;
        @(posedge clk_sys_i);
        host_cs_i <= 1'b0;
        host_rd_i <= 1'b0;
        host_wr_i <= 1'b0;
    endtask
    task automatic t_ports;
        apb(0, `PPBM_OFF_PORTA | 12'h800, 0);
        chk("reset port a", rd, 32'hff);
        apb(1, `PPBM_OFF_PORTA, 32'h0f);
        repeat (4) @(posedge clk_sys_i);
        apb(0, `PPBM_OFF_PORTA, 0);
        chk("pin levels", rd, 32'h0a);
        apb(0, `PPBM_OFF_PORTA | 12'h800, 0);
        chk("rmw read", rd, 32'h0f);
    endtask
    task automatic t_edges;
        apb(1, `PPBM_OFF_IEN, 32'h1);
        pa_ext <= 8'h59;
        repeat (6) @(posedge clk_sys_i);
        chk("irq set", irq_o, 1'b1);
        apb(0, `PPBM_OFF_IFLAG, 0);
        chk("edge flags", rd & 32'h3, 32'h3);
        apb(1, `PPBM_OFF_IFLAG, 32'h3);
        repeat (3) @(posedge clk_sys_i);
        chk("irq clear", irq_o, 1'b0);
    endtask
    task automatic t_portb;
        apb(1, `PPBM_OFF_PORTB, 32'ha5);
        apb(1, `PPBM_OFF_MODE, 32'h40);
        repeat (3) @(posedge clk_sys_i);
        chk("port b out", {portb_oe_n_o, portb_o}, 16'h00a5);
        apb(1, `PPBM_OFF_MODE, 32'h00);
        repeat (3) @(posedge clk_sys_i);
        chk("port b in", portb_oe_n_o, 8'hff);
    endtask
    task automatic t_bus(input logic [31:0] req);
        apb(1, `PPBM_OFF_BUSREQ, req);
        do apb(0, `PPBM_OFF_BUSREQ, 0); while (rd[0] !== 1'b0);
    endtask
    task automatic t_mux;
        apb(1, `PPBM_OFF_MODE, 32'hc0);
        t_bus(32'h003c_1123);
        chk("ext write", u_mem.mem[12'h123], 8'h3c);
        t_bus(32'h0000_0123);
        apb(0, `PPBM_OFF_BUSRD, 0);
        chk("ext read", rd, 32'h3c);
        apb(0, 12'h3f0, 0);
        chk("unmapped", err, 1'b1);
    endtask
    task automatic t_host;
        host(0, 0, 8'h77);
        apb(0, `PPBM_OFF_HOST_IN, 0);
        chk("host data in", rd[7:0], 8'h77);
        apb(1, `PPBM_OFF_MODE, 32'h20);
        apb(1, `PPBM_OFF_HOST_OUT, 32'h99);
        repeat (2) @(negedge clk_sys_i);
        chk("int line full", {portc_oe_n_o[6], portc_o[6]}, 2'b00);
        host(1, 0, 8'h00);
        @(negedge clk_sys_i);
        chk("host data out", host_data_o, 8'h99);
        @(negedge clk_sys_i);
        chk("int line empty", {portc_oe_n_o[6], portc_o[6]}, 2'b01);
        host(1, 1, 8'h00);
        @(negedge clk_sys_i);
        chk("host flags", host_data_o & 8'h82, 8'h00);
        host(0, 1, 8'h5e);
        host(1, 1, 8'h00);
        @(negedge clk_sys_i);
        chk("command flags", host_data_o, 8'h03);
        apb(0, `PPBM_OFF_HOST_IN, 0);
        chk("command in", rd[15:8], 8'h5e);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #20000;
        num_errors++;
        results();
    end
    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        t_ports();
        t_edges();
        t_portb();
        t_mux();
        t_host();
        results();
    end
endmodule // ppbm_top_test
